// ===== hw/boot_image_header_checker.sv
// Purpose: walk a boot image byte stream, pull out and check its header
// Assumes: image bytes arrive in order from offset 0, one per handshake
// Notes:   the code image itself is not consumed; the walk stops at it
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps

module boot_image_header_checker
   import boot_image_pkg::*;
#(
   parameter logic [31:0] VALID_WORD = 32'h5A5A_C3C3, // arbitrary value
   parameter bit          CACHE_EN   = 1'b1,
   parameter logic [31:0] CACHE_BASE = 32'h1F00_0000
)
(
   input  wire logic           aclk,
   input  wire logic           aresetn,
   input  wire logic [7:0]     s_axi_awaddr,
   input  wire logic           s_axi_awvalid,
   output logic                s_axi_awready,
   input  wire logic [31:0]    s_axi_wdata,
   input  wire logic [3:0]     s_axi_wstrb,
   input  wire logic           s_axi_wvalid,
   output logic                s_axi_wready,
   output logic [1:0]          s_axi_bresp,
   output logic                s_axi_bvalid,
   input  wire logic           s_axi_bready,
   input  wire logic [7:0]     s_axi_araddr,
   input  wire logic           s_axi_arvalid,
   output logic                s_axi_arready,
   output logic [31:0]         s_axi_rdata,
   output logic [1:0]          s_axi_rresp,
   output logic                s_axi_rvalid,
   input  wire logic           s_axi_rready,
   input  wire logic           img_valid,
   input  wire logic [7:0]     img_data,
   output logic                img_ready,
   output image_byte_type      tag_out,
   output logic                tag_valid,
   output logic                sram_init_req,
   output logic                init_heap,
   output logic                launch,
   output logic [31:0]         launch_addr,
   output logic [31:0]         fll_frequency_cfg,
   output logic [31:0]         flash_eff_base
);

   // ==================================================================
   // functions
   function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                            input logic [7:0]  b);
      logic [15:0] r;
      r = c ^ {b, 8'h00};
      for (int i = 0; i < 8; i++)
         r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
      return r;
   endfunction

   function automatic logic in_window(input logic [31:0] a,
                                      input logic [31:0] lo,
                                      input logic [31:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction

   function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                              input logic [31:0] d,
                                              input logic [3:0]  s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (s[i])
            r[i*8 +: 8] = d[i*8 +: 8];
      return r;
   endfunction

   // ==================================================================
   // state
   typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_CHECK} state_type;

   state_type   state_reg;
   mode_type    mode_reg;
   logic [11:0] ofs_reg;
   logic [31:0] word_reg;
   logic [31:0] word_next;
   logic [15:0] hcrc_reg;
   logic [15:0] scrc_reg;
   logic        valid_ok_reg;
   logic        hcrc_ok_reg;
   logic        scrc_ok_reg;
   logic [31:0] entry_reg;
   logic [31:0] fll_reg;
   logic [31:0] cfg_a_reg;
   logic [31:0] cfg_b_reg;
   logic [31:0] cfg_c_reg;
   logic [31:0] foffs_reg;
   logic [31:0] enclen_reg;
   logic [31:0] dest_reg;
   logic [31:0] clen_reg;
   logic [31:0] fbase_reg;
   logic [31:0] error_reg;
   logic        done_reg;
   logic        pass_reg;
   logic        start;
   logic        take;
   logic        strict;
   logic        dest_ok;
   logic [31:0] dest_end;

   assign img_ready = (state_reg == ST_LOAD);
   assign take      = img_valid && img_ready;
   // one word assembles low byte first
   // little endian
   assign word_next = {img_data, word_reg[31:8]};
   assign strict    = mode_reg.signed_boot || mode_reg.encrypted_boot_flag;

   // ==================================================================
   // axi4-lite slave
   logic        aw_held_reg;
   logic        w_held_reg;
   logic [7:0]  awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic        do_write;
   logic [31:0] ctrl_wr;
   logic [31:0] rd_word;
   logic        rd_hit;

   assign s_axi_awready = !aw_held_reg;
   assign s_axi_wready  = !w_held_reg;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write      = aw_held_reg && w_held_reg && !s_axi_bvalid;
   assign start = do_write && (awaddr_reg == CTRL_ADDR) && wstrb_reg[0]
                  && wdata_reg[0] && (state_reg == ST_IDLE);
   // control word as written, mode bits sit at 4:1
   assign ctrl_wr = apply_strb({27'h0000000, mode_reg, 1'b0}, wdata_reg,
                               wstrb_reg);

   // address and data are latched independently
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         awaddr_reg  <= 8'h00;
         wdata_reg   <= 32'h0000_0000;
         wstrb_reg   <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end
         else if (do_write)
            aw_held_reg <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end
         else if (do_write)
            w_held_reg <= 1'b0;
      end
   end

   // write response, unmapped or read-only targets answer slverr
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end
      else if (do_write)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (awaddr_reg == CTRL_ADDR ||
                          awaddr_reg == FBASE_ADDR) ? RESP_OKAY
                                                    : RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // writable registers; mode is frozen while a walk runs
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mode_reg  <= '0;
         fbase_reg <= FBASE_RESET;
      end
      else if (do_write)
      begin
         if (awaddr_reg == CTRL_ADDR && state_reg == ST_IDLE)
            mode_reg <= ctrl_wr[4:1];
         if (awaddr_reg == FBASE_ADDR)
            fbase_reg <= apply_strb(fbase_reg, wdata_reg, wstrb_reg);
      end
   end

   // read decode
   always_comb
   begin
      rd_hit  = 1'b1;
      rd_word = 32'h0000_0000;
      case (s_axi_araddr)
         CTRL_ADDR:   rd_word = {27'h0000000, mode_reg, 1'b0};
         STATUS_ADDR: rd_word = {28'h0000000, pass_reg, done_reg,
                                 1'b0, (state_reg != ST_IDLE)};
         ERROR_ADDR:  rd_word = error_reg;
         ENTRY_ADDR:  rd_word = entry_reg;
         FLL_ADDR:    rd_word = fll_reg;
         FBASE_ADDR:  rd_word = fbase_reg;
         FEFF_ADDR:   rd_word = flash_eff_base;
         ENCLEN_ADDR: rd_word = enclen_reg;
         DEST_ADDR:   rd_word = dest_reg;
         CLEN_ADDR:   rd_word = clen_reg;
         CFGA_ADDR:   rd_word = cfg_a_reg;
         CFGB_ADDR:   rd_word = cfg_b_reg;
         CFGC_ADDR:   rd_word = cfg_c_reg;
         default:     rd_hit  = 1'b0;
      endcase
   end

   // read answer one cycle after the address is taken
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // ==================================================================
   // image walk
   // fixed layout, walk ends where code begins
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_reg <= ST_IDLE;
         ofs_reg   <= 12'h000;
         word_reg  <= 32'h0000_0000;
      end
      else
      begin
         case (state_reg)
            ST_IDLE:
               if (start)
               begin
                  state_reg <= ST_LOAD;
                  ofs_reg   <= KEY_FIRST_OFS;
               end
            ST_LOAD:
               if (take)
               begin
                  word_reg <= word_next;
                  ofs_reg  <= ofs_reg + 12'h001;
                  if (ofs_reg == CODE_FIRST_OFS - 12'h001)
                     state_reg <= ST_CHECK;
               end
            ST_CHECK:
               state_reg <= ST_IDLE;
            default:
               state_reg <= ST_IDLE;
         endcase
      end
   end

   // per-byte field tag toward the key, signature and aes engines
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tag_valid <= 1'b0;
         tag_out   <= '0;
      end
      else
      begin
         tag_valid      <= take;
         tag_out.data   <= img_data;
         tag_out.offset <= ofs_reg;
         // usb boot drops the security fields
         if (ofs_reg <= KEY_LAST_OFS)
         begin
            tag_out.section <= SEC_KEY;
            tag_out.in_use  <= !mode_reg.usb_boot && mode_reg.signed_boot;
         end
         else if (ofs_reg <= SIG_LAST_OFS)
         begin
            tag_out.section <= SEC_SIG;
            tag_out.in_use  <= !mode_reg.usb_boot && mode_reg.signed_boot;
         end
         else if (ofs_reg < NONCE_FIRST_OFS)
         begin
            tag_out.section <= SEC_LEN;
            tag_out.in_use  <= !mode_reg.usb_boot &&
                               mode_reg.encrypted_boot_flag;
         end
         else if (ofs_reg <= NONCE_LAST_OFS)
         begin
            tag_out.section <= SEC_NONCE;
            tag_out.in_use  <= !mode_reg.usb_boot &&
                               mode_reg.encrypted_boot_flag;
         end
         else
         begin
            tag_out.section <= (ofs_reg < SEC_FIRST_OFS) ? SEC_BOOT_HDR
                             : SEC_SECT_HDR;
            tag_out.in_use  <= 1'b1;
         end
      end
   end

   // running header crcs, stored crc words excluded
   always_ff @(posedge aclk)
   begin
      if (!aresetn || start)
      begin
         hcrc_reg <= CRC_INIT;
         scrc_reg <= CRC_INIT;
      end
      else if (take)
      begin
         if (ofs_reg >= HDR_FIRST_OFS && ofs_reg < HDR_CRC_OFS)
            hcrc_reg <= crc_byte(hcrc_reg, img_data);
         if (ofs_reg >= SEC_FIRST_OFS && ofs_reg < SEC_CRC_OFS)
            scrc_reg <= crc_byte(scrc_reg, img_data);
      end
   end

   // field capture on the last byte of each word
   always_ff @(posedge aclk)
   begin
      if (!aresetn || start)
      begin
         valid_ok_reg <= 1'b0;
         hcrc_ok_reg  <= 1'b0;
         scrc_ok_reg  <= 1'b0;
         entry_reg    <= 32'h0000_0000;
         fll_reg      <= 32'h0000_0000;
         cfg_a_reg    <= 32'h0000_0000;
         cfg_b_reg    <= 32'h0000_0000;
         cfg_c_reg    <= 32'h0000_0000;
         foffs_reg    <= 32'h0000_0000;
         enclen_reg   <= 32'h0000_0000;
         dest_reg     <= 32'h0000_0000;
         clen_reg     <= 32'h0000_0000;
      end
      else if (take)
      begin
         case (ofs_reg)
            ENC_LEN_OFS + WORD_LAST_BYTE:
               if (mode_reg.encrypted_boot_flag)
                  enclen_reg <= word_next;
            VALID_WORD_OFS + WORD_LAST_BYTE:
               valid_ok_reg <= (word_next == VALID_WORD);
            ENTRY_OFS + WORD_LAST_BYTE:
               entry_reg <= word_next;
            FLL_OFS + WORD_LAST_BYTE:
               fll_reg <= word_next;
            CFG_A_OFS + WORD_LAST_BYTE:
               if (!strict && !mode_reg.usb_boot)
                  cfg_a_reg <= word_next;
            CFG_B_OFS + WORD_LAST_BYTE:
               if (!strict && !mode_reg.usb_boot)
                  cfg_b_reg <= word_next;
            CFG_C_OFS + WORD_LAST_BYTE:
               if (!strict)
                  cfg_c_reg <= word_next;
            FLASH_OFS_OFS + WORD_LAST_BYTE:
               if (!strict && !mode_reg.usb_boot)
                  foffs_reg <= word_next;
            // low half crc, high half zero
            HDR_CRC_OFS + WORD_LAST_BYTE:
               hcrc_ok_reg <= (word_next[15:0] == hcrc_reg) &&
                              (word_next[31:16] == 16'h0000);
            CODE_LEN_OFS + WORD_LAST_BYTE:
               clen_reg <= word_next;
            DEST_OFS + WORD_LAST_BYTE:
               dest_reg <= word_next;
            SEC_CRC_OFS + WORD_LAST_BYTE:
               scrc_ok_reg <= (word_next[15:0] == scrc_reg) &&
                              (word_next[31:16] == 16'h0000);
            default:
               ;
         endcase
      end
   end

   // ==================================================================
   // checks and hand-off
   // offset applied only when enabled
   assign flash_eff_base = cfg_a_reg[FLASH_OFFSET_EN_BIT]
                           ? fbase_reg + foffs_reg : fbase_reg;
   assign fll_frequency_cfg = fll_reg;

   // whole image must sit inside one window; zero length means one byte
   assign dest_end = dest_reg + ((clen_reg == 32'h0000_0000) ? 32'h0
                                 : clen_reg - 32'h1);
   assign dest_ok = (in_window(dest_reg, CODE_DATA_BUS_LO, CODE_DATA_BUS_HI) &&
                     in_window(dest_end, CODE_DATA_BUS_LO, CODE_DATA_BUS_HI)) ||
                    (in_window(dest_reg, SBUS_LO, SBUS_HI) &&
                     in_window(dest_end, SBUS_LO, SBUS_HI)) ||
                    (CACHE_EN &&
                     in_window(dest_reg, CACHE_BASE,
                               CACHE_BASE + CACHE_SIZE - 32'h1) &&
                     in_window(dest_end, CACHE_BASE,
                               CACHE_BASE + CACHE_SIZE - 32'h1));

   // verdict, error code and launch; error code clears on start
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         error_reg   <= 32'h0000_0000;
         done_reg    <= 1'b0;
         pass_reg    <= 1'b0;
         launch      <= 1'b0;
         launch_addr <= 32'h0000_0000;
      end
      else if (start)
      begin
         error_reg <= 32'h0000_0000;
         done_reg  <= 1'b0;
         pass_reg  <= 1'b0;
         launch    <= 1'b0;
      end
      else if (state_reg == ST_CHECK)
      begin
         error_reg[ERR_VALID_WORD_BIT] <= !valid_ok_reg;
         error_reg[ERR_SEC_HDR_BIT]    <= !scrc_ok_reg;
         error_reg[ERR_LOAD_BIT]       <= !dest_ok || !hcrc_ok_reg;
         done_reg <= 1'b1;
         pass_reg <= valid_ok_reg && hcrc_ok_reg && scrc_ok_reg && dest_ok;
         launch   <= valid_ok_reg && hcrc_ok_reg && scrc_ok_reg && dest_ok;
         launch_addr <= entry_reg;
      end
      else
         launch <= 1'b0;
   end

   // loader sram init request, heap kept on deep wake
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sram_init_req <= 1'b0;
         init_heap     <= 1'b1;
      end
      else
      begin
         sram_init_req <= start;
         if (start)
            init_heap <= !ctrl_wr[4];
      end
   end

endmodule

// ===== hw/boot_image_pkg.sv
// Purpose: shared constants and types of the boot image header checker
// Assumes: image offsets fit in 12 bits, 32-bit AXI4-Lite register bus
// Notes:   all offsets are byte offsets from the first image byte
// =====================================================================
// package
package boot_image_pkg;
   // image field offsets
   localparam logic [11:0] KEY_FIRST_OFS   = 12'h000;
   localparam logic [11:0] KEY_LAST_OFS    = 12'h125;
   localparam logic [11:0] SIG_FIRST_OFS   = 12'h126;
   localparam logic [11:0] SIG_LAST_OFS    = 12'h225;
   localparam logic [11:0] ENC_LEN_OFS     = 12'h226;
   localparam logic [11:0] NONCE_FIRST_OFS = 12'h22A;
   localparam logic [11:0] NONCE_LAST_OFS  = 12'h239;
   localparam logic [11:0] HDR_FIRST_OFS   = 12'h23A;
   localparam logic [11:0] VALID_WORD_OFS  = 12'h246;
   localparam logic [11:0] ENTRY_OFS       = 12'h24A;
   localparam logic [11:0] FLL_OFS         = 12'h24E;
   localparam logic [11:0] CFG_A_OFS       = 12'h256;
   localparam logic [11:0] CFG_B_OFS       = 12'h25A;
   localparam logic [11:0] CFG_C_OFS       = 12'h25E;
   localparam logic [11:0] FLASH_OFS_OFS   = 12'h262;
   localparam logic [11:0] HDR_CRC_OFS     = 12'h286;
   localparam logic [11:0] SEC_FIRST_OFS   = 12'h28A;
   localparam logic [11:0] CODE_LEN_OFS    = 12'h28E;
   localparam logic [11:0] DEST_OFS        = 12'h296;
   localparam logic [11:0] SEC_CRC_OFS     = 12'h2B6;
   localparam logic [11:0] CODE_FIRST_OFS  = 12'h2BA;
   localparam logic [11:0] WORD_LAST_BYTE  = 12'h003;
   // crc-16-ccitt
   localparam logic [15:0] CRC_POLY        = 16'h1021;
   localparam logic [15:0] CRC_INIT        = 16'hFFFF;
   // error code fields, flash offset enable bit of cfg a
   localparam int          ERR_VALID_WORD_BIT = 16;
   localparam int          ERR_SEC_HDR_BIT    = 17;
   localparam int          ERR_LOAD_BIT       = 18;
   localparam int          FLASH_OFFSET_EN_BIT = 0;
   // load destination windows
   localparam logic [31:0] CODE_DATA_BUS_LO         = 32'h0010_0000;
   localparam logic [31:0] CODE_DATA_BUS_HI         = 32'h0015_7FFF;
   localparam logic [31:0] SBUS_LO         = 32'h2000_0000;
   localparam logic [31:0] SBUS_HI         = 32'h2001_FFFF;
   localparam logic [31:0] CACHE_SIZE      = 32'h0000_8000;
   // loader private sram
   localparam logic [31:0] RSV_LO          = 32'h2000_0000;
   localparam logic [31:0] RSV_HI          = 32'h2000_5657;
   // register byte offsets
   localparam logic [7:0]  CTRL_ADDR       = 8'h00;
   localparam logic [7:0]  STATUS_ADDR     = 8'h04;
   localparam logic [7:0]  ERROR_ADDR      = 8'h08;
   localparam logic [7:0]  ENTRY_ADDR      = 8'h0C;
   localparam logic [7:0]  FLL_ADDR        = 8'h10;
   localparam logic [7:0]  FBASE_ADDR      = 8'h14;
   localparam logic [7:0]  FEFF_ADDR       = 8'h18;
   localparam logic [7:0]  ENCLEN_ADDR     = 8'h1C;
   localparam logic [7:0]  DEST_ADDR       = 8'h20;
   localparam logic [7:0]  CLEN_ADDR       = 8'h24;
   localparam logic [7:0]  CFGA_ADDR       = 8'h28;
   localparam logic [7:0]  CFGB_ADDR       = 8'h2C;
   localparam logic [7:0]  CFGC_ADDR       = 8'h30;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;
   localparam logic [31:0] FBASE_RESET     = 32'h0000_0000;

   typedef enum logic [2:0]
   {
      SEC_KEY, SEC_SIG, SEC_LEN, SEC_NONCE, SEC_BOOT_HDR, SEC_SECT_HDR,
      SEC_CODE
   } section_type;

   typedef struct packed
   {
      logic        wake_deep;
      logic        usb_boot;
      logic        encrypted_boot_flag;
      logic        signed_boot;
   } mode_type;

   typedef struct packed
   {
      logic [7:0]  data;
      logic [11:0] offset;
      section_type section;
      logic        in_use;
   } image_byte_type;
endpackage

// ===== verif/boot_image_header_checker_bench.sv
// Purpose: self-checking bench of the boot image header checker
// Assumes: flash model streams the image
// Notes:   bus driven and sampled at rising edges
`timescale 1ns/1ps
module boot_image_header_checker_bench
   import boot_image_pkg::*;
;
   localparam logic [31:0] VW = 32'hC0DE_1234; // arbitrary value
   localparam logic [31:0] ENTRY = 32'h0010_0401, FLL = 32'h0000_0C35;
   localparam logic [31:0] ENC = 32'h0000_0280, OFS = 32'h0004_0000;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
   logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, img_valid, img_ready, tag_valid, sram_init_req;
   logic init_heap, launch;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, img_data;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, launch_addr;
   logic [31:0] fll_frequency_cfg, flash_eff_base, d;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   image_byte_type tag_out;
   int errors = 0, comparisons = 0, launches = 0, inits = 0;
   always #50 aclk = ~aclk;
   boot_image_header_checker #(.VALID_WORD(VW)) boot_image_header_checker_i
      (.*);
   flash_image_model #(.ENTRY(ENTRY), .FLL(FLL), .ENC(ENC), .OFS(OFS))
      flash_image_model_i (.*);
   // pulse counters, sampled mid-cycle
   always @(negedge aclk)
   begin
      launches += (launch === 1'b1);
      inits += (sram_init_req === 1'b1);
   end
   task automatic print_verdict();
      if (errors == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(string n, logic [31:0] e, g);
      comparisons++;
      if (g !== e)
      begin
         errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   // one write (w=1) or read, each channel released when taken
   task automatic bus(bit w, logic [7:0] a, logic [31:0] v);
      bit b;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_bready <= w;
      s_axi_arvalid <= !w;
      s_axi_rready <= !w;
      for (int n = 0; n < 50 && !b; n++)
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         b = w ? s_axi_bvalid : s_axi_rvalid;
         r = w ? s_axi_bresp : s_axi_rresp;
         d = s_axi_rdata;
      end
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      if (!b) errors++;
      if (!b) print_verdict();
   endtask
   task automatic rchk(string n, logic [7:0] a, logic [31:0] e);
      bus(0, a, 0);
      chk(n, e, d);
   endtask
   // build image, start, poll until idle
   task automatic run(logic [31:0] ctrl, cfg, vw, bit bad);
      flash_image_model_i.build(vw, cfg, bad);
      launches = 0;
      inits = 0;
      bus(1, CTRL_ADDR, ctrl);
      d = 32'h1;
      for (int n = 0; n < 400 && d[0] !== 1'b0; n++)
         bus(0, STATUS_ADDR, 0);
      if (d[0] !== 1'b0) errors++;
      if (d[0] !== 1'b0) print_verdict();
   endtask
   task automatic t_reset();
      rchk("fbase", FBASE_ADDR, FBASE_RESET);
      rchk("status", STATUS_ADDR, 32'h0);
      bus(0, 8'hFC, 0);
      chk("unmapped resp", RESP_SLVERR, r);
      bus(1, ERROR_ADDR, 32'hFFFF_FFFF);
      chk("ro write resp", RESP_SLVERR, r);
   endtask
   task automatic t_signed();
      run(32'h7, 32'h1, VW, 0);
      rchk("status", STATUS_ADDR, 32'hC);
      rchk("error", ERROR_ADDR, 32'h0);
      rchk("entry", ENTRY_ADDR, ENTRY);
      rchk("fll", FLL_ADDR, FLL);
      rchk("enclen", ENCLEN_ADDR, ENC);
      rchk("cfga", CFGA_ADDR, 32'h0);
      chk("launches", 1, launches);
      chk("launch addr", ENTRY, launch_addr);
      chk("fll port", FLL, fll_frequency_cfg);
      chk("sram init", 1, inits);
   endtask
   task automatic t_offset();
      bus(1, FBASE_ADDR, 32'h0000_1000);
      run(32'h1, 32'h1, VW, 0);
      rchk("cfga", CFGA_ADDR, 32'h1);
      rchk("eff base", FEFF_ADDR, 32'h0000_1000 + OFS);
      chk("eff port", 32'h0000_1000 + OFS, flash_eff_base);
      rchk("enclen", ENCLEN_ADDR, 32'h0);
      chk("heap", 1'b1, init_heap);
   endtask
   task automatic t_usb();
      run(32'h19, 32'h1, VW, 0);
      rchk("cfga", CFGA_ADDR, 32'h0);
      rchk("cfgc", CFGC_ADDR, 32'h1);
      chk("heap", 1'b0, init_heap);
   endtask
   task automatic t_bad_word();
      run(32'h1, 32'h1, ~VW, 0);
      rchk("error", ERROR_ADDR, 32'h0001_0000);
      rchk("status", STATUS_ADDR, 32'h4);
      chk("launches", 0, launches);
   endtask
   task automatic t_bad_crc();
      run(32'h1, 32'h1, VW, 1);
      rchk("error", ERROR_ADDR, 32'h0004_0000);
      chk("launches", 0, launches);
   endtask
   initial
   begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_signed();
      t_offset();
      t_usb();
      t_bad_word();
      t_bad_crc();
      print_verdict();
   end
endmodule

// ===== verif/boot_image_props_properties.sv
// Purpose: timing checks on the bus and image stream ports
// Assumes: one clock, synchronous active-low reset
// Notes:   sees top ports only, attached by bind
`timescale 1ns/1ps
// ==========
// checker
module boot_image_props
   import boot_image_pkg::*;
(
   input wire logic           aclk,
   input wire logic           aresetn,
   input wire logic [1:0]     s_axi_bresp,
   input wire logic           s_axi_bvalid,
   input wire logic           s_axi_bready,
   input wire logic           s_axi_arready,
   input wire logic [31:0]    s_axi_rdata,
   input wire logic           s_axi_rvalid,
   input wire logic           s_axi_rready,
   input wire logic           img_valid,
   input wire logic           img_ready,
   input wire image_byte_type tag_out,
   input wire logic           tag_valid,
   input wire logic           launch
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // one image byte taken
   sequence s_take; img_valid && img_ready; endsequence
   // idle two cycles, one launch
   sequence s_idle; !img_ready ##1 (!img_ready && !launch); endsequence
   property p_tag; s_take |=> tag_valid; endproperty
   a_tag: assert property (p_tag) else $error("tag missing");
   property p_notag; !(img_valid && img_ready) |=> !tag_valid; endproperty
   a_notag: assert property (p_notag) else $error("stray tag");
   property p_key; tag_valid |->
      (tag_out.offset <= KEY_LAST_OFS) == (tag_out.section == SEC_KEY);
   endproperty
   a_key: assert property (p_key) else $error("key section");
   property p_crc; tag_valid && tag_out.offset == HDR_CRC_OFS |->
      tag_out.section == SEC_BOOT_HDR; endproperty
   a_crc: assert property (p_crc) else $error("crc section");
   property p_launch; launch |-> s_idle; endproperty
   a_launch: assert property (p_launch) else $error("launch");
   property p_bhold; s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_bhold: assert property (p_bhold) else $error("bvalid dropped");
   property p_rhold; s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_rhold: assert property (p_rhold) else $error("rvalid dropped");
   property p_ar; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_ar: assert property (p_ar) else $error("arready while rvalid");
endmodule

bind boot_image_header_checker boot_image_props props_i (.*);

// ===== verif/flash_image_model.sv
// Purpose: serial flash streaming one boot image from offset 0
// Assumes: build is called while the loader is idle
// Notes:   data toggles while not valid so stale bytes never match
`timescale 1ns/1ps
module flash_image_model
   import boot_image_pkg::*;
#(
   parameter logic [31:0] ENTRY = 32'h0000_0000,
   parameter logic [31:0] FLL   = 32'h0000_0000,
   parameter logic [31:0] ENC   = 32'h0000_0000,
   parameter logic [31:0] OFS   = 32'h0000_0000
)
(
   input  wire logic  aclk,
   input  wire logic  img_ready,
   output logic       img_valid = 1'b0,
   output logic [7:0] img_data = 8'h00
);
   logic [7:0] mem [0:1023];
   int         idx = 'h2BA;
   function automatic void put(int o, logic [31:0] v);
      for (int k = 0; k < 4; k++)
         mem[o + k] = v[8 * k +: 8];
   endfunction
   function automatic logic [15:0] crc(int lo, hi);
      logic [15:0] c;
      c = CRC_INIT;
      for (int i = lo; i <= hi; i++)
         for (int b = 7; b >= 0; b--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ mem[i][b]) ? CRC_POLY : 16'h0);
      return c;
   endfunction
   // field order, code kept out of loader sram
   task automatic build(logic [31:0] vw, cfg, bit bad);
      for (int i = 0; i < 'h2BA; i++)
         mem[i] = i[7:0] ^ 8'hA5;
      put(ENC_LEN_OFS, ENC);
      put(VALID_WORD_OFS, vw);
      put(ENTRY_OFS, ENTRY);
      put(FLL_OFS, FLL);
      put(CFG_A_OFS, cfg);
      put(CFG_C_OFS, cfg);
      put(FLASH_OFS_OFS, OFS);
      put(CODE_LEN_OFS, 32'h0000_0100);
      put(DEST_OFS, CODE_DATA_BUS_LO);
      // crc in low half, upper half zero
      put(SEC_CRC_OFS, {16'h0000, crc(SEC_FIRST_OFS, 'h2B5)});
      put(HDR_CRC_OFS, {16'h0000, crc(HDR_FIRST_OFS, 'h285) ^ {15'h0, bad}});
      idx = 0;
   endtask
   // byte held until taken
   always @(posedge aclk)
   begin
      if (img_valid && img_ready)
         idx = idx + 1;
      img_valid <= idx < 'h2BA;
      img_data <= (idx < 'h2BA) ? mem[idx] : ~img_data;
   end
endmodule
